//--- hdl/prs_pkg.sv
// constants shared by the power-up reset sequencer
package prs_pkg;

   // ======================================================
   // clocking and hold timing
   localparam int CLK_HZ = 125_000_000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int HOLD_TIME_MS = 60;
   localparam int HOLD_TICKS = HOLD_TIME_MS * (REF_CLK_HZ / 1000);
   // fractional divider: add TICK_INC, wrap at TICK_MOD gives 20 MHz ticks at 125 MHz
   localparam int TICK_INC = 4;
   localparam int TICK_MOD = 25;
   // longest wait for the mirror array to report parked
   localparam int PARK_TIME_NS = 20_000;
   localparam int PARK_CYCLES = PARK_TIME_NS / CLK_PERIOD_NS;

   // ======================================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_GATE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_HOLD = 8'h0c;

   // ======================================================
   // field positions
   localparam int CTRL_LOW_POWER = 0;
   localparam int CTRL_IO18_EN = 1;
   localparam int CTRL_PERIPH_CLK = 2;
   localparam int CTRL_PERIPH_RUN = 3;
   localparam int GATE_W = 4;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_PLL_RUN = 4;
   localparam int ST_PROC_RUN = 5;
   localparam int ST_PARK_BUSY = 6;
   localparam int ST_CAUSE_WDOG = 8;
   localparam int ST_CAUSE_LAMP = 9;
   localparam int ST_CAUSE_WARN = 10;

   // ======================================================
   // reset values
   localparam logic [GATE_W-1:0] GATE_RESET = 4'hf;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   // sequencer states
   typedef enum logic [2:0] {
      SQ_OFF,
      SQ_HOLD,
      SQ_RUN,
      SQ_PARK,
      SQ_DOWN,
      SQ_SYSRST
   } prs_state_t;

endpackage

//--- hdl/prs_sequencer.sv
// power-up and system-reset sequencer with AHB-Lite register slave
// What this block does
// - Sense low: all device pins high impedance
// - Sense rising edge releases only the master PLL
// - Rest stays in reset 60 ms more
// - Hold expiry releases processor resets, boot starts
// - Init: normal power, processor clocks full, released
// - Other clocks off, resets held until software
// - Power gating defaults to all regions powered
// - Same defaults on every system reset event
// - Low power before reset keeps 1.8 V off
// - Processor enables 1.8 V, clocks, then DRAM
// - Warning parks mirror array, then enters reset
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module prs_sequencer #(
   parameter int HOLD_TICKS = prs_pkg::HOLD_TICKS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // power monitor pins, asynchronous
   input wire logic power_on_sense,
   input wire logic supply_fail_warning,
   // system reset events from on-chip logic, same clock
   input wire logic watchdog_reset_evt,
   input wire logic lamp_strike_reset_evt,
   // mirror array park handshake, same clock
   input wire logic mirror_parked,
   output logic mirror_park_req,
   // resets and clock controls
   output logic master_pll_rst_n,
   output logic proc_rst_n,
   output logic proc_clk_full_rate,
   output logic periph_clk_en,
   output logic periph_rst_n,
   // power controls
   output logic [prs_pkg::GATE_W-1:0] power_gate_en,
   output logic io18_supply_en,
   output logic low_power_mode,
   output logic pins_hiz
);
   localparam int CW = $clog2(HOLD_TICKS + 1);
   localparam int PW = $clog2(prs_pkg::PARK_CYCLES + 1);

   // ======================================================
   // pin synchronisation and reference ticks
   prs_sync_if #(.W(2)) pin_if ();
   logic sense_s;
   logic warn_s;
   logic ref_tick;
   logic sense_d_ff;
   logic nxt_sense_d;

   assign pin_if.raw = {supply_fail_warning, power_on_sense};
   assign sense_s = pin_if.sync[0];
   assign warn_s = pin_if.sync[1];

   prs_sync #(.W(2)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .sif(pin_if)
   );

   logic hold_run;
   prs_tick_div u_tick (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(hold_run),
      .tick(ref_tick)
   );

   // ======================================================
   // sequencer state
   prs_pkg::prs_state_t st_ff, nxt_st;
   logic [CW-1:0] hold_cnt_ff, nxt_hold_cnt;
   logic [PW-1:0] park_cnt_ff, nxt_park_cnt;
   logic sys_evt;

   assign sys_evt = watchdog_reset_evt | lamp_strike_reset_evt;
   assign hold_run = (st_ff == prs_pkg::SQ_HOLD);

   // next state; loss of sense overrides everything else
   always_comb begin
      nxt_st = st_ff;
      nxt_hold_cnt = hold_cnt_ff;
      nxt_park_cnt = park_cnt_ff;
      nxt_sense_d = sense_s;
      case (st_ff)
         prs_pkg::SQ_OFF: begin
            nxt_hold_cnt = '0;
            if (sense_s && !sense_d_ff) begin
               nxt_st = prs_pkg::SQ_HOLD;
            end
         end
         prs_pkg::SQ_HOLD: begin
            if (ref_tick) begin
               nxt_hold_cnt = hold_cnt_ff + CW'(1);
            end
            if (hold_cnt_ff == CW'(HOLD_TICKS)) begin
               nxt_st = prs_pkg::SQ_RUN;
            end
         end
         prs_pkg::SQ_RUN: begin
            if (warn_s) begin
               nxt_st = prs_pkg::SQ_PARK;
               nxt_park_cnt = '0;
            end else if (sys_evt) begin
               nxt_st = prs_pkg::SQ_SYSRST;
            end
         end
         prs_pkg::SQ_PARK: begin
            // a mirror array that never answers must not block the reset
            nxt_park_cnt = park_cnt_ff + PW'(1);
            if (mirror_parked || park_cnt_ff == PW'(prs_pkg::PARK_CYCLES)) begin
               nxt_st = prs_pkg::SQ_DOWN;
            end
         end
         prs_pkg::SQ_DOWN: begin
            nxt_hold_cnt = '0;
            if (!warn_s) begin
               nxt_st = prs_pkg::SQ_HOLD;
            end
         end
         prs_pkg::SQ_SYSRST: begin
            nxt_hold_cnt = '0;
            nxt_st = prs_pkg::SQ_HOLD;
         end
         default: begin
            nxt_st = prs_pkg::SQ_OFF;
         end
      endcase
      if (!sense_s) begin
         nxt_st = prs_pkg::SQ_OFF;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= prs_pkg::SQ_OFF;
         hold_cnt_ff <= '0;
         park_cnt_ff <= '0;
         sense_d_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         hold_cnt_ff <= nxt_hold_cnt;
         park_cnt_ff <= nxt_park_cnt;
         sense_d_ff <= nxt_sense_d;
      end
   end

   // ======================================================
   // ahb-lite address phase capture; zero wait states
   logic ap_valid, wr_pend_ff, nxt_wr_pend;
   logic [7:0] wr_addr_ff, nxt_wr_addr;
   logic [31:0] rdata_ff, nxt_rdata, status_word;

   assign ap_valid = hsel && htrans[1] && hready;

   // ======================================================
   // control and power registers
   logic low_power_ff, nxt_low_power, io18_ff, nxt_io18;
   logic pclk_ff, nxt_pclk, prun_ff, nxt_prun;
   logic [prs_pkg::GATE_W-1:0] gate_ff, nxt_gate;
   logic [2:0] cause_ff, nxt_cause;
   logic defaults_now, do_wr;
   logic master_pll_rst_n_ff, proc_rst_n_ff, park_req_ff;

   // every reset entry reapplies the power-up defaults
   assign defaults_now = (st_ff == prs_pkg::SQ_OFF) || (st_ff == prs_pkg::SQ_SYSRST)
      || (st_ff == prs_pkg::SQ_DOWN);
   assign do_wr = wr_pend_ff && (st_ff == prs_pkg::SQ_RUN);

   always_comb begin
      nxt_low_power = low_power_ff;
      nxt_io18 = io18_ff;
      nxt_pclk = pclk_ff;
      nxt_prun = prun_ff;
      nxt_gate = gate_ff;
      nxt_cause = cause_ff;
      // software only steers the control and gating registers while the sequencer is in SQ_RUN
      if (do_wr && wr_addr_ff == prs_pkg::OFF_CTRL) begin
         nxt_low_power = hwdata[prs_pkg::CTRL_LOW_POWER];
         nxt_io18 = hwdata[prs_pkg::CTRL_IO18_EN];
         nxt_pclk = hwdata[prs_pkg::CTRL_PERIPH_CLK];
         nxt_prun = hwdata[prs_pkg::CTRL_PERIPH_RUN];
      end
      if (do_wr && wr_addr_ff == prs_pkg::OFF_GATE) begin
         nxt_gate = hwdata[prs_pkg::GATE_W-1:0];
      end
      // write-one-to-clear of the reset cause bits
      if (wr_pend_ff && wr_addr_ff == prs_pkg::OFF_STATUS) begin
         nxt_cause = cause_ff & ~hwdata[prs_pkg::ST_CAUSE_WARN:prs_pkg::ST_CAUSE_WDOG];
      end
      if (defaults_now) begin
         nxt_low_power = 1'b0;
         nxt_pclk = 1'b0;
         nxt_prun = 1'b0;
         nxt_gate = prs_pkg::GATE_RESET;
         // 1.8 V supply is exempt unless low power was entered first or the sequencer is in SQ_OFF
         if (low_power_ff || st_ff == prs_pkg::SQ_OFF) begin
            nxt_io18 = 1'b0;
         end
      end
      // a new cause wins over a clear in the same cycle
      if (st_ff == prs_pkg::SQ_RUN && !warn_s) begin
         nxt_cause[0] = nxt_cause[0] | watchdog_reset_evt;
         nxt_cause[1] = nxt_cause[1] | lamp_strike_reset_evt;
      end
      if (st_ff == prs_pkg::SQ_RUN && warn_s) begin
         nxt_cause[2] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_power_ff <= 1'b0;
         io18_ff <= 1'b0;
         pclk_ff <= 1'b0;
         prun_ff <= 1'b0;
         gate_ff <= prs_pkg::GATE_RESET;
         cause_ff <= '0;
      end else begin
         low_power_ff <= nxt_low_power;
         io18_ff <= nxt_io18;
         pclk_ff <= nxt_pclk;
         prun_ff <= nxt_prun;
         gate_ff <= nxt_gate;
         cause_ff <= nxt_cause;
      end
   end

   // ======================================================
   // read data, selected in the address phase
   always_comb begin
      status_word = '0;
      status_word[prs_pkg::ST_STATE_LSB +: 3] = st_ff;
      status_word[prs_pkg::ST_PLL_RUN] = master_pll_rst_n_ff;
      status_word[prs_pkg::ST_PROC_RUN] = proc_rst_n_ff;
      status_word[prs_pkg::ST_PARK_BUSY] = park_req_ff;
      status_word[prs_pkg::ST_CAUSE_WARN:prs_pkg::ST_CAUSE_WDOG] = cause_ff;
      nxt_wr_pend = ap_valid && hwrite;
      nxt_wr_addr = ap_valid ? {haddr[7:2], 2'b00} : wr_addr_ff;
      nxt_rdata = rdata_ff;
      if (ap_valid && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            prs_pkg::OFF_CTRL: nxt_rdata = {28'h000_0000, prun_ff, pclk_ff, io18_ff,
               low_power_ff};
            prs_pkg::OFF_GATE: nxt_rdata = {28'h000_0000, gate_ff};
            prs_pkg::OFF_STATUS: nxt_rdata = status_word;
            prs_pkg::OFF_HOLD: nxt_rdata = 32'(hold_cnt_ff);
            default: nxt_rdata = prs_pkg::RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
         rdata_ff <= '0;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         rdata_ff <= nxt_rdata;
      end
   end

   // ======================================================
   // registered pin-facing outputs
   logic nxt_pll_rst_n, nxt_proc_rst_n, nxt_park_req, hiz_ff, nxt_hiz, ready_ff;

   always_comb begin
      nxt_pll_rst_n = (nxt_st != prs_pkg::SQ_OFF);
      nxt_proc_rst_n = (nxt_st == prs_pkg::SQ_RUN) || (nxt_st == prs_pkg::SQ_PARK);
      nxt_park_req = (nxt_st == prs_pkg::SQ_PARK);
      nxt_hiz = !sense_s;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_pll_rst_n_ff <= 1'b0;
         proc_rst_n_ff <= 1'b0;
         park_req_ff <= 1'b0;
         hiz_ff <= 1'b1;
         ready_ff <= 1'b0;
      end else begin
         master_pll_rst_n_ff <= nxt_pll_rst_n;
         proc_rst_n_ff <= nxt_proc_rst_n;
         park_req_ff <= nxt_park_req;
         hiz_ff <= nxt_hiz;
         ready_ff <= 1'b1;
      end
   end

   assign hrdata = rdata_ff;
   assign hreadyout = ready_ff;
   assign hresp = 1'b0;
   assign mirror_park_req = park_req_ff;
   assign master_pll_rst_n = master_pll_rst_n_ff;
   assign proc_rst_n = proc_rst_n_ff;
   assign proc_clk_full_rate = !low_power_ff;
   assign periph_clk_en = pclk_ff;
   assign periph_rst_n = prun_ff;
   assign power_gate_en = gate_ff;
   assign io18_supply_en = io18_ff;
   assign low_power_mode = low_power_ff;
   assign pins_hiz = hiz_ff;

   initial begin
      if (HOLD_TICKS < 1) $error("prs_sequencer: HOLD_TICKS must be at least 1");
   end
endmodule

`default_nettype wire

//--- hdl/prs_sync.sv
// two-flop synchroniser bank for pins from outside the hclk domain
`timescale 1ns/1ps
`default_nettype none

module prs_sync #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pins in, synchronised levels out
   prs_sync_if.sync_side sif
);
   // ======================================================
   // one two-stage chain per bit
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_ff;
         logic stab_ff;
         logic nxt_meta;
         logic nxt_stab;
         // first stage is read only by the second
         always_comb begin
            nxt_meta = sif.raw[g];
            nxt_stab = meta_ff;
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_ff <= 1'b0;
               stab_ff <= 1'b0;
            end else begin
               meta_ff <= nxt_meta;
               stab_ff <= nxt_stab;
            end
         end
         assign sif.sync[g] = stab_ff;
      end
   endgenerate

   initial begin
      if (W < 1) $error("prs_sync: width must be at least 1");
   end
endmodule

`default_nettype wire

//--- hdl/prs_sync_if.sv
// interface carrying asynchronous pins into the synchroniser and back
`timescale 1ns/1ps
`default_nettype none

interface prs_sync_if #(parameter int W = 2);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport sync_side (input raw, output sync);
   modport user_side (output raw, input sync);
endinterface

`default_nettype wire

//--- hdl/prs_tick_div.sv
// fractional divider giving one-cycle ticks at the crystal reference rate
`timescale 1ns/1ps
`default_nettype none

module prs_tick_div #(
   parameter int INC = prs_pkg::TICK_INC,
   parameter int MOD = prs_pkg::TICK_MOD
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // enable, tick output
   input wire logic run,
   output logic tick
);
   localparam int AW = $clog2(MOD + INC + 1);
   logic [AW-1:0] acc_ff;
   logic [AW-1:0] nxt_acc;
   logic tick_ff;
   logic nxt_tick;
   logic [AW-1:0] sum;

   // ======================================================
   // accumulate; average tick rate is exactly clk * INC / MOD
   always_comb begin
      sum = acc_ff + AW'(INC);
      nxt_tick = 1'b0;
      nxt_acc = '0;
      if (run) begin
         if (sum >= AW'(MOD)) begin
            nxt_acc = sum - AW'(MOD);
            nxt_tick = 1'b1;
         end else begin
            nxt_acc = sum;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

   initial begin
      if (INC < 1 || INC > MOD) $error("prs_tick_div: need 1 <= INC <= MOD");
      if (longint'(prs_pkg::CLK_HZ) * INC != longint'(prs_pkg::REF_CLK_HZ) * MOD)
         $error("prs_tick_div: INC/MOD does not give the reference rate");
   end
endmodule

`default_nettype wire

//--- tb/prs_monitor_model.sv
// behavioural power monitor and mirror array on the sequencer's far side
`timescale 1ns/1ps
`default_nettype none

module prs_monitor_model #(
   parameter int SETTLE = 16,
   parameter int PARK_DLY = 6
) (
   // clock
   input wire logic hclk,
   // bench controls
   input wire logic supplies_ok,
   input wire logic brownout,
   input wire logic park_stall,
   // monitor pins
   output logic power_on_sense,
   output logic supply_fail_warning,
   // mirror array handshake
   input wire logic mirror_park_req,
   output logic mirror_parked
);
   int settle_cnt = 0;
   int park_cnt = 0;

   // ==========================================
   // sense rises only once the supplies have been steady a while
   always @(posedge hclk) begin
      settle_cnt <= supplies_ok ? settle_cnt + 1 : 0;
      power_on_sense <= supplies_ok && settle_cnt >= SETTLE;
   end

   // warning ahead of the drop; a stalled array never reports parked
   always @(posedge hclk) begin
      supply_fail_warning <= brownout;
      park_cnt <= mirror_park_req ? park_cnt + 1 : 0;
      mirror_parked <= mirror_park_req && !park_stall && park_cnt >= PARK_DLY;
   end

   initial begin
      power_on_sense = 1'b0;
      supply_fail_warning = 1'b0;
      mirror_parked = 1'b0;
   end
endmodule

`default_nettype wire

//--- tb/prs_seq_chk.sv
// assertion checker watching the power-up reset sequencer ports
`timescale 1ns/1ps
`default_nettype none

module prs_seq_chk #(
   parameter int HOLD_TICKS = prs_pkg::HOLD_TICKS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // monitor, event and mirror inputs
   input wire logic power_on_sense,
   input wire logic supply_fail_warning,
   input wire logic watchdog_reset_evt,
   input wire logic lamp_strike_reset_evt,
   input wire logic mirror_parked,
   // sequencer outputs
   input wire logic mirror_park_req,
   input wire logic master_pll_rst_n,
   input wire logic proc_rst_n,
   input wire logic proc_clk_full_rate,
   input wire logic periph_clk_en,
   input wire logic periph_rst_n,
   input wire logic [prs_pkg::GATE_W-1:0] power_gate_en,
   input wire logic low_power_mode,
   input wire logic pins_hiz
);
   // ==========================================
   // hold length: ticks come 4 in every 25 clocks
   localparam int HOLD_CYC = HOLD_TICKS * prs_pkg::TICK_MOD / prs_pkg::TICK_INC;
   int hold_cnt_ff;
   int nxt_hold_cnt;

   // pll free, processor held; a warning restarts it since the down wait is unbounded
   always_comb begin
      nxt_hold_cnt = hold_cnt_ff + 1;
      if (!master_pll_rst_n || proc_rst_n || supply_fail_warning) begin
         nxt_hold_cnt = 0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_ff <= 0;
      end else begin
         hold_cnt_ff <= nxt_hold_cnt;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   hiz_low_sense_a: assert property (!power_on_sense [*3] |=> ##[0:1]
      (pins_hiz && !master_pll_rst_n && !proc_rst_n)) else $error("pins live with sense low");
   pll_alone_a: assert property ($rose(master_pll_rst_n) |-> !proc_rst_n)
      else $error("processor freed with pll");
   hold_min_a: assert property ($rose(proc_rst_n) |-> hold_cnt_ff >= HOLD_CYC - 8)
      else $error("hold too short");
   hold_max_a: assert property (hold_cnt_ff <= HOLD_CYC + 8)
      else $error("hold too long");
   boot_dflt_a: assert property ($rose(proc_rst_n) |-> proc_clk_full_rate && !low_power_mode)
      else $error("boot not in normal power");
   periph_off_a: assert property ($rose(proc_rst_n) |-> !periph_clk_en && !periph_rst_n)
      else $error("peripherals live at boot");
   gate_all_a: assert property ($rose(proc_rst_n) |-> power_gate_en == 4'hf)
      else $error("gating not all on at boot");
   sysrst_evt_a: assert property ((watchdog_reset_evt || lamp_strike_reset_evt) &&
      proc_rst_n && !mirror_park_req && !supply_fail_warning |=> ##[0:1] !proc_rst_n)
      else $error("reset event ignored");
   park_first_a: assert property (mirror_park_req |-> proc_rst_n)
      else $error("reset before park");
   park_done_a: assert property (mirror_park_req && mirror_parked |=> ##[0:1]
      (!mirror_park_req && !proc_rst_n)) else $error("no reset after park");
endmodule

bind prs_sequencer prs_seq_chk #(.HOLD_TICKS(HOLD_TICKS)) prs_seq_chk_inst (
   .hclk(hclk), .hresetn(hresetn), .power_on_sense(power_on_sense),
   .supply_fail_warning(supply_fail_warning), .watchdog_reset_evt(watchdog_reset_evt),
   .lamp_strike_reset_evt(lamp_strike_reset_evt), .mirror_parked(mirror_parked),
   .mirror_park_req(mirror_park_req), .master_pll_rst_n(master_pll_rst_n),
   .proc_rst_n(proc_rst_n), .proc_clk_full_rate(proc_clk_full_rate),
   .periph_clk_en(periph_clk_en), .periph_rst_n(periph_rst_n),
   .power_gate_en(power_gate_en), .low_power_mode(low_power_mode), .pins_hiz(pins_hiz));

`default_nettype wire

//--- tb/test_power_up_reset_sequencer.sv
// self-checking bench for the power-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
   end \
end

module test_power_up_reset_sequencer;
   // hold shortened to keep the run short; expected length in clocks
   localparam int HT = 20;
   localparam int HC = HT * prs_pkg::TICK_MOD / prs_pkg::TICK_INC;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic sense, warn, wdog, lamp, parked, park_req, pll_n, proc_n, full, pclk, prst;
   logic io18, lowp, hiz, ok, brown, stall;
   logic [3:0] gate;
   int fails = 0;
   int checks_done = 0;

   // ==========================================
   // clock, single slave on the bus
   assign hready = hreadyout;
   always #4 hclk = ~hclk;

   prs_sequencer #(.HOLD_TICKS(HT)) prs_sequencer_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .power_on_sense(sense),
      .supply_fail_warning(warn), .watchdog_reset_evt(wdog), .lamp_strike_reset_evt(lamp),
      .mirror_parked(parked), .mirror_park_req(park_req), .master_pll_rst_n(pll_n),
      .proc_rst_n(proc_n), .proc_clk_full_rate(full), .periph_clk_en(pclk),
      .periph_rst_n(prst), .power_gate_en(gate), .io18_supply_en(io18),
      .low_power_mode(lowp), .pins_hiz(hiz));

   prs_monitor_model prs_monitor_model_inst (
      .hclk(hclk), .supplies_ok(ok), .brownout(brown), .park_stall(stall),
      .power_on_sense(sense), .supply_fail_warning(warn), .mirror_park_req(park_req),
      .mirror_parked(parked));

   // ==========================================
   // helpers
   task automatic summarize();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // bounded wait for one output to reach a level; n counts clocks spent
   task automatic wait_on(input int sel, input logic v, input int lim, output int n);
      logic cur;
      n = 0;
      forever begin
         cur = sel == 0 ? pll_n : sel == 1 ? proc_n : sel == 2 ? park_req : hiz;
         if (cur === v) begin
            return;
         end
         if (n >= lim) begin
            fails++;
            $display("[ERR] wait %0d exp %0d got timeout", sel, v);
            summarize();
         end
         @(posedge hclk);
         n++;
      end
   endtask

   // one word: address phase held until ready, then the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      r = hrdata;
      if (n >= 100) begin
         fails++;
         $display("[ERR] bus exp ready got timeout");
         summarize();
      end
   endtask

   // write, then one more edge so the new levels are visible
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      @(posedge hclk);
   endtask

   task automatic pulse(input int k);
      @(posedge hclk);
      if (k == 0) begin
         wdog <= 1'b1;
      end else begin
         lamp <= 1'b1;
      end
      @(posedge hclk);
      wdog <= 1'b0;
      lamp <= 1'b0;
   endtask

   // ==========================================
   // scenarios
   task automatic t_power_up();
      int n;
      logic [31:0] r;
      `CHK("hiz", 1'b1, hiz)
      `CHK("pll_n", 1'b0, pll_n)
      ok <= 1'b1;
      wait_on(0, 1'b1, 300, n);
      `CHK("proc_n", 1'b0, proc_n)
      wait_on(1, 1'b1, HC + 20, n);
      `CHK("hold", 1'b1, n >= HC - 8 && n <= HC + 8)
      `CHK("full", 1'b1, full && !lowp && !hiz)
      `CHK("periph", 2'b00, {pclk, prst})
      `CHK("gate", 4'hf, gate)
      bus(1'b0, prs_pkg::OFF_STATUS, 32'h0, r);
      `CHK("status", 32'h32, r)
      bus(1'b0, 8'h10, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      `CHK("hresp", 1'b0, hresp)
      bus(1'b0, prs_pkg::OFF_HOLD, 32'h0, r);
      `CHK("hold_rd", HT, r)
   endtask

   task automatic t_sw_enable();
      logic [31:0] r;
      wr(prs_pkg::OFF_CTRL, 32'h6);
      `CHK("io18_clk", 3'b110, {io18, pclk, prst})
      wr(prs_pkg::OFF_CTRL, 32'he);
      `CHK("prst", 1'b1, prst)
      wr(prs_pkg::OFF_GATE, 32'h5);
      bus(1'b0, prs_pkg::OFF_GATE, 32'h0, r);
      `CHK("gate_rd", 32'h5, r)
   endtask

   // watchdog then lamp strike: defaults return, 1.8 V kept
   task automatic t_sys_event();
      int n;
      logic [31:0] r;
      for (int k = 0; k < 2; k++) begin
         wr(prs_pkg::OFF_CTRL, 32'he);
         wr(prs_pkg::OFF_GATE, 32'h3);
         pulse(k);
         wait_on(1, 1'b0, 5, n);
         wr(prs_pkg::OFF_GATE, 32'h0);
         wait_on(1, 1'b1, HC + 20, n);
         `CHK("dflt", 7'h4f, {io18, pclk, prst, gate})
         bus(1'b0, prs_pkg::OFF_STATUS, 32'h0, r);
         `CHK("cause", 1'b1, r[prs_pkg::ST_CAUSE_WDOG + k])
         wr(prs_pkg::OFF_STATUS, 32'h300);
      end
   endtask

   task automatic t_low_power();
      int n;
      wr(prs_pkg::OFF_CTRL, 32'h3);
      `CHK("lp", 2'b10, {lowp, full})
      pulse(0);
      wait_on(1, 1'b0, 5, n);
      wait_on(1, 1'b1, HC + 20, n);
      `CHK("io18_off", 3'b001, {io18, lowp, full})
      wr(prs_pkg::OFF_CTRL, 32'h2);
      `CHK("io18_on", 1'b1, io18)
   endtask

   // prompt array, then one that never answers and hits the park timeout
   task automatic t_warning();
      int n;
      for (int s = 0; s < 2; s++) begin
         wr(prs_pkg::OFF_GATE, 32'h0);
         stall <= s[0];
         brown <= 1'b1;
         wait_on(2, 1'b1, 10, n);
         `CHK("run_park", 1'b1, proc_n)
         wait_on(2, 1'b0, 2600, n);
         `CHK("down", 1'b0, proc_n)
         `CHK("park_len", 1'b1, s == 0 ? n < 50 : n >= 2490 && n <= 2510)
         brown <= 1'b0;
         wait_on(1, 1'b1, HC + 30, n);
         `CHK("back", 4'hf, gate)
      end
      stall <= 1'b0;
   endtask

   // supply loss parks every pin; gate writes outside run are ignored
   task automatic t_power_loss();
      int n;
      ok <= 1'b0;
      wait_on(3, 1'b1, 30, n);
      `CHK("off", 2'b00, {pll_n, proc_n})
      wr(prs_pkg::OFF_GATE, 32'h0);
      `CHK("gate_ro", 4'hf, gate)
   endtask

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      {wdog, lamp, ok, brown, stall} = '0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_power_up();
      t_sw_enable();
      t_sys_event();
      t_low_power();
      t_warning();
      t_power_loss();
      summarize();
   end
endmodule

`default_nettype wire
